/* hw/cmcd_params.svh */
/*
 * Named constants of the clock mode configuration decoder: widths, register offsets,
 * register field positions and reset values.
 * Assumes it is included by its bare name from the package and the design modules.
 */
`ifndef CMCD_PARAMS_SVH
`define CMCD_PARAMS_SVH

`define CMCD_ADDR_W        12
`define CMCD_DATA_W        32
`define CMCD_RATIO_W       7
`define CMCD_RATIO_HI_W    4
`define CMCD_RATIO_LO_W    3
`define CMCD_FACT_W        5
`define CMCD_TEST_W        8

`define CMCD_OFF_STATUS    12'h000
`define CMCD_OFF_RATIO     12'h004
`define CMCD_OFF_EVENT     12'h008
`define CMCD_OFF_TEST      12'h00C

`define CMCD_ST_MODE_LSB   0
`define CMCD_ST_MODE_MSB   1
`define CMCD_ST_RANGE_BIT  2
`define CMCD_ST_VALID_BIT  3
`define CMCD_ST_UNSUP_BIT  4
`define CMCD_ST_INPOR_BIT  5

`define CMCD_RT_CODE_LSB   0
`define CMCD_RT_CODE_MSB   6
`define CMCD_RT_COMMS_LSB  8
`define CMCD_RT_COMMS_MSB  12
`define CMCD_RT_CORE_LSB   16
`define CMCD_RT_CORE_MSB   20

`define CMCD_EV_CHANGE_BIT 0

`define CMCD_TEST_RST      8'h00
`define CMCD_FACT_NONE     5'h00

`endif

/* hw/cmcd_pkg.sv */
/*
 * Types shared by the clock mode configuration decoder: clocking modes, bridge
 * reference ranges, the strap bundle and the decoded configuration bundle.
 * Assumes cmcd_params.svh is on the include path.
 */
package cmcd_pkg;
	`include "cmcd_params.svh"

	// Gray along local, host, agent
	typedef enum logic [1:0] {
		CMCD_MODE_LOCAL = 2'h0,
		CMCD_MODE_HOST  = 2'h1,
		CMCD_MODE_AGENT = 2'h3
	} cmcd_mode_t;

	typedef enum logic {
		CMCD_RANGE_50_66 = 1'b0,
		CMCD_RANGE_25_50 = 1'b1
	} cmcd_range_t;

	typedef struct packed {
		logic                         bridge_clk_mode_select;
		logic                         host_agent_select;
		logic                         range_select;
		logic [`CMCD_RATIO_HI_W-1:0]  ratio_high;
		logic [`CMCD_RATIO_LO_W-1:0]  ratio_low;
	} cmcd_straps_t;

	// Factors are in half units: 5 means 2.5
	typedef struct packed {
		logic                         valid;
		logic                         unsupported;
		cmcd_mode_t                   mode;
		cmcd_range_t                  range;
		logic [`CMCD_RATIO_W-1:0]     ratio_code;
		logic [`CMCD_FACT_W-1:0]      comms_mult_halves;
		logic [`CMCD_FACT_W-1:0]      core_mult_halves;
	} cmcd_clk_cfg_t;
endpackage

/* hw/cmcd_ratio_decode.sv */
/*
 * Ratio code lookup: maps mode and seven-bit code to comms and core factors.
 * Assumes a registered consumer; purely combinational.
 */
`include "cmcd_params.svh"
module cmcd_ratio_decode (
	input  cmcd_pkg::cmcd_mode_t         mode,
	input  wire logic [`CMCD_RATIO_W-1:0] code,
	output logic      [`CMCD_FACT_W-1:0]  comms_mult_halves,
	output logic      [`CMCD_FACT_W-1:0]  core_mult_halves,
	output logic                          unsupported
);
	import cmcd_pkg::*;

	logic [2*`CMCD_FACT_W-1:0] pair;

	always_comb begin
		pair = {`CMCD_FACT_NONE, `CMCD_FACT_NONE};
		case (code)
			7'h00: pair = {5'h06, 5'h08};
			7'h01: pair = {5'h06, 5'h0A};
			7'h02: pair = {5'h08, 5'h08};
			7'h03: pair = {5'h08, 5'h0A};
			7'h04: pair = {5'h04, 5'h05};
			7'h05: pair = {5'h04, 5'h06};
			7'h06: pair = {5'h05, 5'h05};
			7'h07: pair = {5'h05, 5'h06};
			7'h08: pair = {5'h04, 5'h08};
			7'h09: pair = {5'h04, 5'h0A};
			7'h0A: pair = {5'h04, 5'h0C};
			7'h0D: pair = {5'h06, 5'h08};
			7'h0E: pair = {5'h06, 5'h0A};
			7'h0F: pair = {5'h06, 5'h0C};
			7'h47: pair = {5'h06, 5'h0B};
			7'h12: pair = {5'h08, 5'h08};
			7'h13: pair = {5'h08, 5'h0A};
			7'h14: pair = {5'h08, 5'h0C};
			7'h15: pair = {5'h08, 5'h0E};
			7'h16: pair = {5'h08, 5'h10};
			7'h18: pair = {5'h0A, 5'h0A};
			7'h19: pair = {5'h0A, 5'h0C};
			7'h1A: pair = {5'h0A, 5'h0E};
			7'h1B: pair = {5'h0A, 5'h10};
			7'h1E: pair = {5'h0C, 5'h0C};
			7'h1F: pair = {5'h0C, 5'h0E};
			7'h20: pair = {5'h0C, 5'h10};
			7'h2D: pair = {5'h04, 5'h04};
			7'h2E: pair = {5'h04, 5'h05};
			7'h2F: pair = {5'h04, 5'h06};
			7'h30: pair = {5'h04, 5'h07};
			7'h31: pair = {5'h04, 5'h08};
			7'h32: pair = {5'h04, 5'h09};
			default: pair = {`CMCD_FACT_NONE, `CMCD_FACT_NONE};
		endcase
		// Bridge-mode tables are not held here, so those modes never program factors
		if (mode != CMCD_MODE_LOCAL) begin
			pair = {`CMCD_FACT_NONE, `CMCD_FACT_NONE};
		end
	end

	assign comms_mult_halves = pair[2*`CMCD_FACT_W-1:`CMCD_FACT_W];
	assign core_mult_halves  = pair[`CMCD_FACT_W-1:0];
	assign unsupported       = (pair[`CMCD_FACT_W-1:0] == `CMCD_FACT_NONE);
endmodule

/* hw/cmcd_sync.sv */
/*
 * Two-flop synchroniser for a bundle of independent slow levels.
 * Assumes each bit is a quasi-static level; bits are not kept coherent with each other.
 */
module cmcd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import cmcd_pkg::*;

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* hw/cmcd_top.sv */
/*
 * Clock mode configuration decoder: captures board straps at power-on reset release,
 * decodes clocking mode, bridge range and, in local mode only, ratio factors for the PLLs and dividers,
 * and exposes them over an APB slave with a strap-change flag and a test register.
 * Assumes the strap pins and power-on reset pin are asynchronous to pclk and that
 * presetn is asserted at least once before the first power-on reset release.
 */
// Added by the designer: the APB slave port and the register addresses.
`include "cmcd_params.svh"
module cmcd_top (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [`CMCD_ADDR_W-1:0]    paddr,
	input  wire logic [`CMCD_DATA_W-1:0]    pwdata,
	output logic      [`CMCD_DATA_W-1:0]    prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       power_on_reset_input_n,
	input  wire logic                       bridge_clk_mode_select,
	input  wire logic                       host_agent_select,
	input  wire logic                       bridge_clock_range_select,
	input  wire logic [`CMCD_RATIO_LO_W-1:0] ratio_strap_pins,
	input  wire logic [`CMCD_RATIO_HI_W-1:0] ratio_code_high_bits,
	input  wire logic                       jtag_trst_n,
	output cmcd_pkg::cmcd_clk_cfg_t         clk_cfg,
	output logic      [`CMCD_TEST_W-1:0]    test_data
);
	import cmcd_pkg::*;

	cmcd_straps_t                straps_raw;
	cmcd_straps_t                straps_s;
	cmcd_straps_t                straps_cap_reg;
	logic                        por_s;
	logic                        por_prev_reg;
	logic                        por_release;
	cmcd_mode_t                  mode_next;
	logic [`CMCD_RATIO_W-1:0]    code_next;
	logic [`CMCD_FACT_W-1:0]     comms_next;
	logic [`CMCD_FACT_W-1:0]     core_next;
	logic                        unsup_next;
	cmcd_clk_cfg_t               cfg_reg;
	logic                        strap_changed_reg;
	logic                        change_clear;
	logic [`CMCD_TEST_W-1:0]     test_data_reg;
	logic                        test_rst_n;
	logic                        setup_phase;
	logic                        access_wr;
	logic [`CMCD_DATA_W-1:0]     rd_data;
	logic                        rd_err;
	logic [`CMCD_DATA_W-1:0]     prdata_reg;
	logic                        slverr_reg;

	assign straps_raw.bridge_clk_mode_select = bridge_clk_mode_select;
	assign straps_raw.host_agent_select      = host_agent_select;
	assign straps_raw.range_select           = bridge_clock_range_select;
	assign straps_raw.ratio_high             = ratio_code_high_bits;
	assign straps_raw.ratio_low              = ratio_strap_pins;

	// Pins are asynchronous to pclk
	cmcd_sync #(
		.W ($bits(cmcd_straps_t))
	) u_strap_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (straps_raw),
		.q     (straps_s)
	);

	cmcd_sync #(
		.W (1)
	) u_por_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (power_on_reset_input_n),
		.q     (por_s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_prev_reg <= 1'b0;
		end else begin
			por_prev_reg <= por_s;
		end
	end

	assign por_release = por_s & ~por_prev_reg;

	always_comb begin
		if (straps_s.bridge_clk_mode_select) begin
			mode_next = CMCD_MODE_LOCAL;
		end else if (straps_s.host_agent_select) begin
			mode_next = CMCD_MODE_AGENT;
		end else begin
			mode_next = CMCD_MODE_HOST;
		end
	end

	assign code_next = {straps_s.ratio_high, straps_s.ratio_low};

	cmcd_ratio_decode u_decode (
		.mode              (mode_next),
		.code              (code_next),
		.comms_mult_halves (comms_next),
		.core_mult_halves  (core_next),
		.unsupported       (unsup_next)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
		end else if (!por_s) begin
			cfg_reg.valid <= 1'b0;
		end else if (por_release) begin
			cfg_reg.valid             <= 1'b1;
			cfg_reg.unsupported       <= unsup_next;
			cfg_reg.mode              <= mode_next;
			cfg_reg.range             <= cmcd_range_t'(straps_s.range_select);
			cfg_reg.ratio_code        <= code_next;
			cfg_reg.comms_mult_halves <= comms_next;
			cfg_reg.core_mult_halves  <= core_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			straps_cap_reg <= '0;
		end else if (por_release) begin
			straps_cap_reg <= straps_s;
		end
	end

	assign clk_cfg = cfg_reg;

	// Strap moves after capture are only reported; a new set beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_changed_reg <= 1'b0;
		end else if (!por_s) begin
			strap_changed_reg <= 1'b0;
		end else if (cfg_reg.valid && (straps_s != straps_cap_reg)) begin
			strap_changed_reg <= 1'b1;
		end else if (change_clear) begin
			strap_changed_reg <= 1'b0;
		end
	end

	assign test_rst_n = presetn & jtag_trst_n;

	always_ff @(posedge pclk or negedge test_rst_n) begin
		if (!test_rst_n) begin
			test_data_reg <= `CMCD_TEST_RST;
		end else if (access_wr && (paddr == `CMCD_OFF_TEST)) begin
			test_data_reg <= pwdata[`CMCD_TEST_W-1:0];
		end
	end

	assign test_data = test_data_reg;

	assign setup_phase  = psel & ~penable;
	assign access_wr    = psel & penable & pwrite;
	assign change_clear = access_wr && (paddr == `CMCD_OFF_EVENT) && pwdata[`CMCD_EV_CHANGE_BIT];

	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		case (paddr)
			`CMCD_OFF_STATUS: begin
				rd_data[`CMCD_ST_MODE_MSB:`CMCD_ST_MODE_LSB] = cfg_reg.mode;
				rd_data[`CMCD_ST_RANGE_BIT]                  = cfg_reg.range;
				rd_data[`CMCD_ST_VALID_BIT]                  = cfg_reg.valid;
				rd_data[`CMCD_ST_UNSUP_BIT]                  = cfg_reg.unsupported;
				rd_data[`CMCD_ST_INPOR_BIT]                  = ~por_s;
			end
			`CMCD_OFF_RATIO: begin
				rd_data[`CMCD_RT_CODE_MSB:`CMCD_RT_CODE_LSB]   = cfg_reg.ratio_code;
				rd_data[`CMCD_RT_COMMS_MSB:`CMCD_RT_COMMS_LSB] = cfg_reg.comms_mult_halves;
				rd_data[`CMCD_RT_CORE_MSB:`CMCD_RT_CORE_LSB]   = cfg_reg.core_mult_halves;
			end
			`CMCD_OFF_EVENT: begin
				rd_data[`CMCD_EV_CHANGE_BIT] = strap_changed_reg;
			end
			`CMCD_OFF_TEST: begin
				rd_data[`CMCD_TEST_W-1:0] = test_data_reg;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	// Read data is sampled in setup so prdata comes straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? '0 : rd_data;
			slverr_reg <= rd_err;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = slverr_reg & psel & penable;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence por_rel_s;
		por_s && !por_prev_reg;
	endsequence

	sequence cfg_loaded_s;
		cfg_reg.valid && $changed(cfg_reg.valid);
	endsequence

	mode_set_a: assert property (cfg_loaded_s |->
			cfg_reg.mode inside {CMCD_MODE_LOCAL, CMCD_MODE_HOST, CMCD_MODE_AGENT})
		else $error("Captured mode is not one of the three modes");

	mode_select_a: assert property (cfg_loaded_s |->
			cfg_reg.mode == (straps_cap_reg.bridge_clk_mode_select ? CMCD_MODE_LOCAL :
			(straps_cap_reg.host_agent_select ? CMCD_MODE_AGENT : CMCD_MODE_HOST)))
		else $error("Mode does not follow the select straps");

	range_pick_a: assert property (cfg_loaded_s |-> cfg_reg.range == cmcd_range_t'(straps_cap_reg.range_select))
		else $error("Bridge range does not follow its strap");

	code_form_a: assert property (por_rel_s |=>
			cfg_reg.ratio_code == {$past(straps_s.ratio_high), $past(straps_s.ratio_low)})
		else $error("Ratio code bit order wrong");

	capture_time_a: assert property (por_rel_s |=> cfg_reg.valid ##1 cfg_reg.valid || !por_s)
		else $error("Configuration not captured one cycle after release");

	hold_config_a: assert property ((por_prev_reg && $past(por_prev_reg)) |-> $stable(cfg_reg))
		else $error("Configuration moved without a power-on reset");

	local_table_a: assert property ((cfg_reg.valid && cfg_reg.mode == CMCD_MODE_LOCAL
			&& cfg_reg.ratio_code == 7'h06) |->
			(cfg_reg.comms_mult_halves == 5'h05 && cfg_reg.core_mult_halves == 5'h05))
		else $error("Code 0x06 does not give 2.5 and 2.5");

	factors_set_a: assert property ((cfg_reg.valid && !cfg_reg.unsupported) |->
			(cfg_reg.comms_mult_halves != `CMCD_FACT_NONE && cfg_reg.core_mult_halves != `CMCD_FACT_NONE))
		else $error("Supported configuration without programmed factors");

	unsup_flag_a: assert property ((cfg_reg.valid && cfg_reg.unsupported) |->
			(cfg_reg.comms_mult_halves == `CMCD_FACT_NONE && cfg_reg.core_mult_halves == `CMCD_FACT_NONE))
		else $error("Unsupported code still programs factors");

	code_taken_a: assert property ((por_s && !por_prev_reg && straps_s.ratio_high == 4'h0
			&& straps_s.ratio_low == 3'h0 && straps_s.bridge_clk_mode_select) |=>
			(cfg_reg.comms_mult_halves == 5'h06 && cfg_reg.core_mult_halves == 5'h08))
		else $error("Code zero does not give factors 3 and 4");

	test_reset_a: assert property (!jtag_trst_n |-> test_data_reg == `CMCD_TEST_RST)
		else $error("Test register not held in reset by test reset");

	por_invalid_a: assert property (!por_s |=> !cfg_reg.valid)
		else $error("Configuration still valid during power-on reset");

	valid_rise_a: assert property ($rose(cfg_reg.valid) |-> $past(por_release))
		else $error("Configuration became valid without a release");

	// A strap move in the same cycle as a software clear must leave the flag set
	event_set_a: assert property ((por_s && cfg_reg.valid && (straps_s != straps_cap_reg)) |=>
			strap_changed_reg)
		else $error("Strap change not flagged");

	event_hold_a: assert property ((por_s && strap_changed_reg && !change_clear) |=> strap_changed_reg)
		else $error("Strap change flag dropped without a clear");

	event_clear_a: assert property ((por_s && change_clear && !(cfg_reg.valid && (straps_s != straps_cap_reg))) |=>
			!strap_changed_reg)
		else $error("Strap change flag not cleared");

	straps_kept_a: assert property ((por_prev_reg && $past(por_prev_reg)) |-> $stable(straps_cap_reg))
		else $error("Captured straps moved outside a release");

	factor_load_a: assert property (por_rel_s |=>
			(cfg_reg.comms_mult_halves == $past(comms_next) && cfg_reg.core_mult_halves == $past(core_next)
			&& cfg_reg.unsupported == $past(unsup_next)))
		else $error("Decoded factors not loaded at release");

	local_code8_a: assert property ((cfg_reg.valid && cfg_reg.mode == CMCD_MODE_LOCAL && cfg_reg.ratio_code == 7'h08) |->
			(cfg_reg.comms_mult_halves == 5'h04 && cfg_reg.core_mult_halves == 5'h08))
		else $error("Code 0x08 does not give 2 and 4");

	bridge_unsup_a: assert property ((cfg_reg.valid && cfg_reg.mode != CMCD_MODE_LOCAL) |-> cfg_reg.unsupported)
		else $error("Bridge mode without a factor table not flagged");

	slow_range_a: assert property ((cfg_loaded_s && cfg_reg.mode != CMCD_MODE_LOCAL && straps_cap_reg.range_select) |->
			cfg_reg.range == CMCD_RANGE_25_50)
		else $error("High range strap does not give the low frequency range");
endmodule

/* tb/cmcd_strap_model.sv */
/*
 * Board strap and power-on reset source for the decoder.
 * Assumes the bench changes its requests just after a rising pclk edge.
 */
`include "cmcd_params.svh"
module cmcd_strap_model (
	input  wire logic                        pclk,
	input  cmcd_pkg::cmcd_straps_t           straps_req,
	input  wire logic                        por_req,
	output logic                             power_on_reset_input_n,
	output logic                             bridge_clk_mode_select,
	output logic                             host_agent_select,
	output logic                             bridge_clock_range_select,
	output logic [`CMCD_RATIO_LO_W-1:0]      ratio_strap_pins,
	output logic [`CMCD_RATIO_HI_W-1:0]      ratio_code_high_bits
);
	timeunit 1ns;
	timeprecision 100ps;
	import cmcd_pkg::*;

	always_ff @(posedge pclk) begin
		power_on_reset_input_n <= ~por_req;
	end

	always_ff @(posedge pclk) begin
		bridge_clk_mode_select    <= straps_req.bridge_clk_mode_select;
		host_agent_select         <= straps_req.host_agent_select;
		bridge_clock_range_select <= straps_req.range_select;
		ratio_code_high_bits      <= straps_req.ratio_high;
		ratio_strap_pins          <= straps_req.ratio_low;
	end
endmodule

/* tb/tb_clock_mode_config_decoder.sv */
/*
 * Self-checking bench: APB master, strap source model, mode and ratio checks.
 * Assumes the decoder answers APB with zero wait states.
 */
`include "cmcd_params.svh"
module tb_clock_mode_config_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	import cmcd_pkg::*;

	logic                     pclk;
	logic                     presetn;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [`CMCD_ADDR_W-1:0]  paddr;
	logic [`CMCD_DATA_W-1:0]  pwdata;
	logic [`CMCD_DATA_W-1:0]  prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     por_n;
	logic                     sel;
	logic                     ha;
	logic                     rg;
	logic [2:0]               lo;
	logic [3:0]               hi;
	logic                     jtag_trst_n;
	cmcd_straps_t             straps;
	logic                     por_req;
	cmcd_clk_cfg_t            clk_cfg;
	logic [`CMCD_TEST_W-1:0]  test_data;
	logic [31:0]              rd;
	logic                     err;
	int                       failures;
	int                       checked;

	cmcd_strap_model strap (.pclk(pclk), .straps_req(straps), .por_req(por_req),
		.power_on_reset_input_n(por_n), .bridge_clk_mode_select(sel), .host_agent_select(ha),
		.bridge_clock_range_select(rg), .ratio_strap_pins(lo), .ratio_code_high_bits(hi));

	cmcd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_on_reset_input_n(por_n), .bridge_clk_mode_select(sel),
		.host_agent_select(ha), .bridge_clock_range_select(rg), .ratio_strap_pins(lo),
		.ratio_code_high_bits(hi), .jtag_trst_n(jtag_trst_n), .clk_cfg(clk_cfg),
		.test_data(test_data));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait for a captured configuration to show
	task automatic wait_valid;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (clk_cfg.valid !== 1'b1 && n < 20);
		if (clk_cfg.valid !== 1'b1) begin
			failures++;
			end_sim();
		end
	endtask

	// Straps settle well before the power-on reset release
	task automatic por_cycle(input logic [9:0] s);
		@(posedge pclk);
		straps  <= s;
		por_req <= 1'b1;
		repeat (6) @(posedge pclk);
		por_req <= 1'b0;
		wait_valid();
	endtask

	task automatic chk_cfg(input logic [1:0] m, input logic r, input logic [6:0] c,
		input logic [4:0] cm, input logic [4:0] co, input logic u);
		chk(32'(clk_cfg.mode), 32'(m), "mode");
		chk(32'(clk_cfg.range), 32'(r), "range");
		chk(32'(clk_cfg.ratio_code), 32'(c), "code");
		chk(32'(clk_cfg.comms_mult_halves), 32'(cm), "comms");
		chk(32'(clk_cfg.core_mult_halves), 32'(co), "core");
		chk(32'(clk_cfg.unsupported), 32'(u), "unsup");
		apb(1'b0, `CMCD_OFF_STATUS, 32'h0);
		chk(rd, {26'h0, 1'b0, u, 1'b1, r, m}, "status");
		apb(1'b0, `CMCD_OFF_RATIO, 32'h0);
		chk(rd, {11'h0, co, 3'h0, cm, 1'b0, c}, "ratio");
	endtask

	task automatic t_reset;
		apb(1'b0, `CMCD_OFF_STATUS, 32'h0);
		chk(rd, 32'h0000_0020, "status rst");
		apb(1'b0, `CMCD_OFF_RATIO, 32'h0);
		chk(rd, 32'h0, "ratio rst");
		apb(1'b0, `CMCD_OFF_TEST, 32'h0);
		chk(rd, 32'h0, "test rst");
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk(32'(err), 32'h1, "unmapped wr");
		apb(1'b0, 12'h010, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped rd");
		$display("t_reset done");
	endtask

	// Local mode table: code, comms halves, core halves, unsupported
	task automatic t_local;
		logic [6:0] c  [12] = '{7'h00, 7'h01, 7'h04, 7'h06, 7'h07, 7'h08,
			7'h0B, 7'h47, 7'h16, 7'h20, 7'h32, 7'h33};
		logic [4:0] cm [12] = '{5'h06, 5'h06, 5'h04, 5'h05, 5'h05, 5'h04,
			5'h00, 5'h06, 5'h08, 5'h0C, 5'h04, 5'h00};
		logic [4:0] co [12] = '{5'h08, 5'h0A, 5'h05, 5'h05, 5'h06, 5'h08,
			5'h00, 5'h0B, 5'h10, 5'h10, 5'h09, 5'h00};
		for (int i = 0; i < 12; i++) begin
			por_cycle({3'b100, c[i]});
			chk_cfg(CMCD_MODE_LOCAL, 1'b0, c[i], cm[i], co[i], co[i] == 5'h00);
		end
		por_cycle({3'b100, 7'h10});
		chk_cfg(CMCD_MODE_LOCAL, 1'b0, 7'h10, 5'h00, 5'h00, 1'b1);
		$display("t_local done");
	endtask

	task automatic t_bridge;
		for (int i = 0; i < 4; i++) begin
			por_cycle({1'b0, i[1], i[0], 7'h00});
			chk_cfg(i[1] ? CMCD_MODE_AGENT : CMCD_MODE_HOST, i[0], 7'h00, 5'h00, 5'h00, 1'b1);
		end
		$display("t_bridge done");
	endtask

	task automatic t_hold;
		por_cycle({3'b100, 7'h06});
		@(posedge pclk);
		straps <= {3'b011, 7'h7F};
		repeat (8) @(posedge pclk);
		chk_cfg(CMCD_MODE_LOCAL, 1'b0, 7'h06, 5'h05, 5'h05, 1'b0);
		apb(1'b1, `CMCD_OFF_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, `CMCD_OFF_EVENT, 32'h0);
		chk(rd, 32'h1, "event set");
		apb(1'b1, `CMCD_OFF_EVENT, 32'h1);
		apb(1'b0, `CMCD_OFF_EVENT, 32'h0);
		chk(rd, 32'h1, "event set wins");
		straps <= {3'b100, 7'h06};
		repeat (8) @(posedge pclk);
		apb(1'b1, `CMCD_OFF_EVENT, 32'h1);
		apb(1'b0, `CMCD_OFF_EVENT, 32'h0);
		chk(rd, 32'h0, "event clr");
		chk_cfg(CMCD_MODE_LOCAL, 1'b0, 7'h06, 5'h05, 5'h05, 1'b0);
		$display("t_hold done");
	endtask

	task automatic t_test;
		apb(1'b1, `CMCD_OFF_TEST, 32'h0000_00A5);
		apb(1'b0, `CMCD_OFF_TEST, 32'h0);
		chk(rd, 32'h0000_00A5, "test rw");
		@(posedge pclk);
		jtag_trst_n <= 1'b0;
		#1;
		chk(32'(test_data), 32'h0, "trst async");
		@(posedge pclk);
		jtag_trst_n <= 1'b1;
		apb(1'b0, `CMCD_OFF_TEST, 32'h0);
		chk(rd, 32'h0, "test clr");
		$display("t_test done");
	endtask

	// Mid-run register reset with the power-on pin high: straps are taken again on release
	task automatic t_warm;
		apb(1'b1, `CMCD_OFF_TEST, 32'h0000_005A);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(32'(clk_cfg), 32'h0, "cfg rst");
		chk(32'(test_data), 32'h0, "test rst mid");
		presetn <= 1'b1;
		wait_valid();
		chk_cfg(CMCD_MODE_LOCAL, 1'b0, 7'h06, 5'h05, 5'h05, 1'b0);
		$display("t_warm done");
	endtask

	initial begin
		failures = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		jtag_trst_n = 1'b1;
		straps = '0;
		por_req = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_local();
		t_bridge();
		t_hold();
		t_test();
		t_warm();
		end_sim();
	end
endmodule
